//--- hw/tmps_timer_regs.v
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "tmps_regs.vh"

// Summary of operation
// - timer b load low half writable only outside 32-bit; always readable
// - in 32-bit the timer a load high half is the timer b load
// - match logic acts only in 32-bit rtc or 16-bit pwm/edge count; edge totals follow edge count in either width
// - 32-bit rtc compares full timer a match against the joined counter
// - in 16-bit timer a match high reads zero, writes leave timer b match
// - pwm level of each timer derives from its count and match values
// - edge count total of each timer is load minus match
// - timer b match holds 16 writable bits reset to ones, upper reserved
// - each timer has an 8-bit prescale reset zero, read back as stored
// - prescale match, reset zero, extends match comparison to 24 bits
// - value registers read live count, or edge timestamp in edge count mode
// - timer a value high half shows timer b count in 32-bit, else zero
// - a match and a load low halves reset ones; high halves by config
module tmps_timer_regs #(
  parameter ADDR_W = 12,
  parameter CNT_W  = 16,
  parameter PRE_W  = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              reset_n,
  // avalon-mm slave
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output wire              waitrequest,
  output wire [31:0]       readdata,
  // timer configuration
  input  wire              cfg32Bit,
  input  wire              cfgRtc,
  input  wire              pwmModeA,
  input  wire              pwmModeB,
  input  wire              edgeModeA,
  input  wire              edgeModeB,
  // counter state
  input  wire [CNT_W-1:0]  countA,
  input  wire [CNT_W-1:0]  countB,
  input  wire [PRE_W-1:0]  prescaleCountA,
  input  wire [PRE_W-1:0]  prescaleCountB,
  input  wire [CNT_W-1:0]  edgeStampA,
  input  wire [CNT_W-1:0]  edgeStampB,
  // settings to the counters
  output wire [CNT_W-1:0]  loadA,
  output wire [CNT_W-1:0]  loadB,
  output wire [PRE_W-1:0]  prescaleA,
  output wire [PRE_W-1:0]  prescaleB,
  // match results
  output reg               rtcMatch,
  output wire              matchEventA,
  output wire              matchEventB,
  output wire              pwmOutA,
  output wire              pwmOutB,
  output wire [CNT_W-1:0]  edgeTotalA,
  output wire [CNT_W-1:0]  edgeTotalB
);

  // registers
  reg  [CNT_W-1:0]  aLoad_q;
  reg  [CNT_W-1:0]  aLoad_d;
  reg  [CNT_W-1:0]  bLoad_q;
  reg  [CNT_W-1:0]  bLoad_d;
  reg  [CNT_W-1:0]  aMatch_q;
  reg  [CNT_W-1:0]  aMatch_d;
  reg  [CNT_W-1:0]  bMatch_q;
  reg  [CNT_W-1:0]  bMatch_d;
  reg  [PRE_W-1:0]  aPre_q;
  reg  [PRE_W-1:0]  aPre_d;
  reg  [PRE_W-1:0]  bPre_q;
  reg  [PRE_W-1:0]  bPre_d;
  reg  [PRE_W-1:0]  aPreMatch_q;
  reg  [PRE_W-1:0]  aPreMatch_d;
  reg  [PRE_W-1:0]  bPreMatch_q;
  reg  [PRE_W-1:0]  bPreMatch_d;

  // bus side
  wire              regWrStrobe;
  wire [ADDR_W-1:0] regAddr;
  wire [31:0]       regWrData;
  wire [3:0]        regByteEn;
  reg  [31:0]       regRdData;

  // mode qualifiers
  wire              mode16;
  wire              rtc32;
  wire              enableA;
  wire              enableB;
  wire [CNT_W-1:0]  valueA;
  wire [CNT_W-1:0]  valueB;
  wire [31:0]       wrWord;

  // byte-enabled merge of write data into an old word
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  be;
    integer      i;
    begin
      mergeBytes = oldWord;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (be[i])
        begin
          mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  // write strobe for one register offset
  function isWrite;
    input [ADDR_W-1:0] addr;
    input [11:0]       ofs;
    begin
      isWrite = regWrStrobe & (addr == ofs[ADDR_W-1:0]);
    end
  endfunction

  assign mode16 = ~cfg32Bit;
  assign rtc32  = cfg32Bit & cfgRtc;
  assign enableA = mode16 & (pwmModeA | edgeModeA);
  assign enableB = mode16 & (pwmModeB | edgeModeB);

  // edge count mode shows the last edge timestamp instead of the live count
  assign valueA = edgeModeA ? edgeStampA : countA;
  assign valueB = edgeModeB ? edgeStampB : countB;

  // reads of written fields merge into the word as software sees it
  assign wrWord = mergeBytes(regRdData, regWrData, regByteEn);

  assign loadA     = aLoad_q;
  assign loadB     = bLoad_q;
  assign prescaleA = aPre_q;
  assign prescaleB = bPre_q;

  tmps_avalon_slave #(
    .ADDR_W (ADDR_W)
  ) uBus (
    .clk         (clk),
    .reset_n     (reset_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .regRdData   (regRdData),
    .regWrStrobe (regWrStrobe),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regByteEn   (regByteEn)
  );

  // read mux; unmapped offsets and reserved bits read as zero
  always @*
  begin
    regRdData = `TMPS_ZERO_WORD;
    case (regAddr)
      `TMPS_OFS_A_LOAD:
      begin
        regRdData = {(cfg32Bit ? bLoad_q : `TMPS_ZERO_HALF), aLoad_q};
      end
      `TMPS_OFS_B_LOAD:
      begin
        regRdData = {`TMPS_ZERO_HALF, bLoad_q};
      end
      `TMPS_OFS_A_MATCH:
      begin
        regRdData = {(cfg32Bit ? bMatch_q : `TMPS_ZERO_HALF), aMatch_q};
      end
      `TMPS_OFS_B_MATCH:
      begin
        regRdData = {`TMPS_ZERO_HALF, bMatch_q};
      end
      `TMPS_OFS_A_PRESCALE:
      begin
        regRdData = {24'h000000, aPre_q};
      end
      `TMPS_OFS_B_PRESCALE:
      begin
        regRdData = {24'h000000, bPre_q};
      end
      `TMPS_OFS_A_PRE_MATCH:
      begin
        regRdData = {24'h000000, aPreMatch_q};
      end
      `TMPS_OFS_B_PRE_MATCH:
      begin
        regRdData = {24'h000000, bPreMatch_q};
      end
      `TMPS_OFS_A_VALUE:
      begin
        regRdData = {(cfg32Bit ? countB : `TMPS_ZERO_HALF), valueA};
      end
      `TMPS_OFS_B_VALUE:
      begin
        regRdData = {`TMPS_ZERO_HALF, valueB};
      end
      default:
      begin
        regRdData = `TMPS_ZERO_WORD;
      end
    endcase
  end

  // next values of the writable fields
  always @*
  begin
    aLoad_d     = aLoad_q;
    bLoad_d     = bLoad_q;
    aMatch_d    = aMatch_q;
    bMatch_d    = bMatch_q;
    aPre_d      = aPre_q;
    bPre_d      = bPre_q;
    aPreMatch_d = aPreMatch_q;
    bPreMatch_d = bPreMatch_q;
    if (isWrite(regAddr, `TMPS_OFS_A_LOAD))
    begin
      aLoad_d = wrWord[`TMPS_HALF_LO_MSB:0];
      if (cfg32Bit)
      begin
        bLoad_d = wrWord[`TMPS_HALF_HI_MSB:`TMPS_HALF_HI_LSB];
      end
    end
    if (isWrite(regAddr, `TMPS_OFS_B_LOAD) & mode16)
    begin
      bLoad_d = wrWord[`TMPS_HALF_LO_MSB:0];
    end
    if (isWrite(regAddr, `TMPS_OFS_A_MATCH))
    begin
      aMatch_d = wrWord[`TMPS_HALF_LO_MSB:0];
      if (cfg32Bit)
      begin
        bMatch_d = wrWord[`TMPS_HALF_HI_MSB:`TMPS_HALF_HI_LSB];
      end
    end
    if (isWrite(regAddr, `TMPS_OFS_B_MATCH))
    begin
      bMatch_d = wrWord[`TMPS_HALF_LO_MSB:0];
    end
    if (isWrite(regAddr, `TMPS_OFS_A_PRESCALE))
    begin
      aPre_d = wrWord[`TMPS_PRE_MSB:0];
    end
    if (isWrite(regAddr, `TMPS_OFS_B_PRESCALE))
    begin
      bPre_d = wrWord[`TMPS_PRE_MSB:0];
    end
    if (isWrite(regAddr, `TMPS_OFS_A_PRE_MATCH))
    begin
      aPreMatch_d = wrWord[`TMPS_PRE_MSB:0];
    end
    if (isWrite(regAddr, `TMPS_OFS_B_PRE_MATCH))
    begin
      bPreMatch_d = wrWord[`TMPS_PRE_MSB:0];
    end
  end

  // high halves live in the timer b fields, so they reset to ones in
  // 32-bit and read as zero in 16-bit without sampling config at reset
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aLoad_q     <= `TMPS_RST_HALF;
      bLoad_q     <= `TMPS_RST_HALF;
      aMatch_q    <= `TMPS_RST_HALF;
      bMatch_q    <= `TMPS_RST_HALF;
      aPre_q      <= `TMPS_RST_PRE;
      bPre_q      <= `TMPS_RST_PRE;
      aPreMatch_q <= `TMPS_RST_PRE;
      bPreMatch_q <= `TMPS_RST_PRE;
    end
    else
    begin
      aLoad_q     <= aLoad_d;
      bLoad_q     <= bLoad_d;
      aMatch_q    <= aMatch_d;
      bMatch_q    <= bMatch_d;
      aPre_q      <= aPre_d;
      bPre_q      <= bPre_d;
      aPreMatch_q <= aPreMatch_d;
      bPreMatch_q <= bPreMatch_d;
    end
  end

  // 32-bit rtc: timer b count forms the upper half of the joined counter
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rtcMatch <= 1'b0;
    end
    else
    begin
      rtcMatch <= rtc32 & ({countB, countA} == {bMatch_q, aMatch_q});
    end
  end

  tmps_match_unit #(
    .CNT_W (CNT_W),
    .PRE_W (PRE_W)
  ) uMatchA (
    .clk           (clk),
    .reset_n       (reset_n),
    .enable        (enableA),
    .pwmMode       (pwmModeA),
    .edgeMode      (edgeModeA),
    .count         (countA),
    .prescaleCount (prescaleCountA),
    .loadValue     (aLoad_q),
    .matchValue    (aMatch_q),
    .prescaleValue (aPre_q),
    .prescaleMatch (aPreMatch_q),
    .matchEvent    (matchEventA),
    .pwmOut        (pwmOutA),
    .edgeTotal     (edgeTotalA)
  );

  tmps_match_unit #(
    .CNT_W (CNT_W),
    .PRE_W (PRE_W)
  ) uMatchB (
    .clk           (clk),
    .reset_n       (reset_n),
    .enable        (enableB),
    .pwmMode       (pwmModeB),
    .edgeMode      (edgeModeB),
    .count         (countB),
    .prescaleCount (prescaleCountB),
    .loadValue     (bLoad_q),
    .matchValue    (bMatch_q),
    .prescaleValue (bPre_q),
    .prescaleMatch (bPreMatch_q),
    .matchEvent    (matchEventB),
    .pwmOut        (pwmOutB),
    .edgeTotal     (edgeTotalB)
  );

endmodule // tmps_timer_regs

//--- hw/tmps_regs.vh
`ifndef TMPS_REGS_VH
`define TMPS_REGS_VH

// register byte offsets
`define TMPS_OFS_A_LOAD        12'h028
`define TMPS_OFS_B_LOAD        12'h02c
`define TMPS_OFS_A_MATCH       12'h030
`define TMPS_OFS_B_MATCH       12'h034
`define TMPS_OFS_A_PRESCALE    12'h038
`define TMPS_OFS_B_PRESCALE    12'h03c
`define TMPS_OFS_A_PRE_MATCH   12'h040
`define TMPS_OFS_B_PRE_MATCH   12'h044
`define TMPS_OFS_A_VALUE       12'h048
`define TMPS_OFS_B_VALUE       12'h04c

// field positions
`define TMPS_HALF_LO_MSB       15
`define TMPS_HALF_HI_LSB       16
`define TMPS_HALF_HI_MSB       31
`define TMPS_PRE_MSB           7

// reset values
`define TMPS_RST_HALF          16'hffff
`define TMPS_RST_PRE           8'h00
`define TMPS_ZERO_HALF         16'h0000
`define TMPS_ZERO_WORD         32'h00000000

// bus answer timing
`define TMPS_WAIT_CYCLES       1

`endif

//--- hw/tmps_avalon_slave.v
`timescale 1ns/100ps
`include "tmps_regs.vh"

module tmps_avalon_slave #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input  wire              clk,
  input  wire              reset_n,
  // avalon-mm slave
  input  wire [ADDR_W-1:0] address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output reg               waitrequest,
  output reg  [31:0]       readdata,
  // register file side
  input  wire [31:0]       regRdData,
  output wire              regWrStrobe,
  output wire [ADDR_W-1:0] regAddr,
  output wire [31:0]       regWrData,
  output wire [3:0]        regByteEn
);

  // one wait cycle: the request is seen, then the answer edge follows
  assign regWrStrobe = write & ~waitrequest;
  assign regAddr     = address;
  assign regWrData   = writedata;
  assign regByteEn   = byteenable;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= `TMPS_ZERO_WORD;
    end
    else if ((read | write) & waitrequest)
    begin
      waitrequest <= 1'b0;
      readdata    <= read ? regRdData : `TMPS_ZERO_WORD;
    end
    else
    begin
      waitrequest <= 1'b1;
    end
  end

endmodule // tmps_avalon_slave

//--- hw/tmps_match_unit.v
`timescale 1ns/100ps
`include "tmps_regs.vh"

module tmps_match_unit #(
  parameter CNT_W = 16,
  parameter PRE_W = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // mode
  input  wire             enable,
  input  wire             pwmMode,
  input  wire             edgeMode,
  // counter state
  input  wire [CNT_W-1:0] count,
  input  wire [PRE_W-1:0] prescaleCount,
  // settings
  input  wire [CNT_W-1:0] loadValue,
  input  wire [CNT_W-1:0] matchValue,
  input  wire [PRE_W-1:0] prescaleValue,
  input  wire [PRE_W-1:0] prescaleMatch,
  // results
  output reg              matchEvent,
  output reg              pwmOut,
  output reg  [CNT_W-1:0] edgeTotal
);

  wire             usePrescale;
  wire             extMatch;

  assign usePrescale = (prescaleValue != {PRE_W{1'b0}});
  // prescaler extends the comparison to the full prescale plus counter width
  assign extMatch = usePrescale ? ({prescaleCount, count} == {prescaleMatch, matchValue})
                                : (count == matchValue);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      matchEvent <= 1'b0;
      pwmOut     <= 1'b0;
      edgeTotal  <= {CNT_W{1'b0}};
    end
    else
    begin
      matchEvent <= enable & extMatch;
      pwmOut     <= enable & pwmMode & (count > matchValue);
      edgeTotal  <= edgeMode ? (loadValue - matchValue) : {CNT_W{1'b0}};
    end
  end

endmodule // tmps_match_unit

//--- tb/tmps_timer_regs_chk.sv
`timescale 1ns/100ps
`include "tmps_regs.vh"

module tmps_timer_regs_chk #(
  parameter ADDR_W = 12,
  parameter CNT_W  = 16,
  parameter PRE_W  = 8
) (
  // clock and reset
  input logic              clk,
  input logic              reset_n,
  // bus
  input logic [ADDR_W-1:0] address,
  input logic              read,
  input logic              write,
  input logic [31:0]       writedata,
  input logic              waitrequest,
  input logic [31:0]       readdata,
  // configuration and counters
  input logic              cfg32Bit,
  input logic              cfgRtc,
  input logic              pwmModeA,
  input logic              edgeModeA,
  input logic              edgeModeB,
  input logic              pwmModeB,
  input logic [CNT_W-1:0]  countA,
  input logic [CNT_W-1:0]  countB,
  input logic [CNT_W-1:0]  edgeStampA,
  // results
  input logic [CNT_W-1:0]  loadB,
  input logic [PRE_W-1:0]  prescaleA,
  input logic              rtcMatch,
  input logic              matchEventA,
  input logic              matchEventB,
  input logic              pwmOutA,
  input logic [CNT_W-1:0]  edgeTotalA
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  sequence s_wr_bload;
    s_take ##0 write && address == `TMPS_OFS_B_LOAD && cfg32Bit;
  endsequence
  sequence s_wr_pre;
    s_take ##0 write && address == `TMPS_OFS_A_PRESCALE;
  endsequence

  property p_answer;
    s_take |=> !waitrequest ##1 waitrequest;
  endproperty
  property p_value_rd;
    s_take ##0 read && address == `TMPS_OFS_A_VALUE |=> readdata ==
      {($past(cfg32Bit) ? $past(countB) : 16'h0000),
       ($past(edgeModeA) ? $past(edgeStampA) : $past(countA))};
  endproperty
  property p_bload_hold;
    s_wr_bload |=> ##1 loadB == $past(loadB, 2);
  endproperty
  property p_pre_wr;
    s_wr_pre |=> ##1 prescaleA == $past(writedata[7:0], 2);
  endproperty
  property p_rtc_off;
    !(cfg32Bit && cfgRtc) |=> !rtcMatch;
  endproperty
  property p_match_a_off;
    (cfg32Bit || !(pwmModeA || edgeModeA)) |=> !matchEventA;
  endproperty
  property p_match_b_off;
    (cfg32Bit || !(pwmModeB || edgeModeB)) |=> !matchEventB;
  endproperty
  property p_pwm_off;
    !pwmModeA |=> !pwmOutA;
  endproperty
  property p_edge_off;
    !edgeModeA |=> edgeTotalA == 16'h0000;
  endproperty

  a_answer:      assert property (p_answer) else $error("bus answer not one wait cycle");
  a_value_rd:    assert property (p_value_rd) else $error("timer a value read wrong");
  a_bload_hold:  assert property (p_bload_hold) else $error("b load changed in 32-bit");
  a_pre_wr:      assert property (p_pre_wr) else $error("prescale a not stored");
  a_rtc_off:     assert property (p_rtc_off) else $error("rtc match outside rtc");
  a_match_a_off: assert property (p_match_a_off) else $error("match a in wrong mode");
  a_match_b_off: assert property (p_match_b_off) else $error("match b in wrong mode");
  a_pwm_off:     assert property (p_pwm_off) else $error("pwm a high outside pwm");
  a_edge_off:    assert property (p_edge_off) else $error("edge total outside edge");
endmodule // tmps_timer_regs_chk

bind tmps_timer_regs tmps_timer_regs_chk #(
  .ADDR_W(ADDR_W), .CNT_W(CNT_W), .PRE_W(PRE_W)
) chk_u (
  .clk, .reset_n, .address, .read, .write, .writedata, .waitrequest, .readdata,
  .cfg32Bit, .cfgRtc, .pwmModeA, .edgeModeA, .edgeModeB, .pwmModeB, .countA, .countB,
  .edgeStampA, .loadB, .prescaleA, .rtcMatch, .matchEventA, .matchEventB, .pwmOutA,
  .edgeTotalA
);

//--- tb/tmps_timer_regs_test.sv
`timescale 1ns/100ps
`include "tmps_regs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tmps_timer_regs_test;
  logic        clk, reset_n, read, write, cfg32Bit, cfgRtc;
  logic        pwmModeA, pwmModeB, edgeModeA, edgeModeB;
  logic [11:0] address;
  logic [31:0] writedata, rdv;
  logic [3:0]  byteenable;
  logic [15:0] countA, countB, edgeStampA, edgeStampB;
  logic [7:0]  prescaleCountA, prescaleCountB;
  wire         waitrequest, rtcMatch, matchEventA, matchEventB, pwmOutA, pwmOutB;
  wire  [31:0] readdata;
  wire  [15:0] loadA, loadB, edgeTotalA, edgeTotalB;
  wire  [7:0]  prescaleA, prescaleB;
  int          failures = 0;
  int          checked = 0;

  tmps_timer_regs dut_u (
    .clk, .reset_n, .address, .read, .write, .writedata, .byteenable, .waitrequest,
    .readdata, .cfg32Bit, .cfgRtc, .pwmModeA, .pwmModeB, .edgeModeA, .edgeModeB,
    .countA, .countB, .prescaleCountA, .prescaleCountB, .edgeStampA, .edgeStampB,
    .loadA, .loadB, .prescaleA, .prescaleB, .rtcMatch, .matchEventA, .matchEventB,
    .pwmOutA, .pwmOutB, .edgeTotalA, .edgeTotalB
  );

  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge;
  // data taken and request released at that same edge
  task automatic bus_acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      failures++;
    rdv = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus_acc(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rdv)
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    bus_acc(1'b1, a, d);
    rd_chk(a, e);
  endtask

  // registered results settle one edge after their inputs
  task tick;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // about 175 cycles of tests; the limit allows about seventeen times that
  initial
  begin
    #60000;
    failures++;
    print_verdict;
  end

  initial
  begin
    reset_n <= 1'b0;
    {read, write, cfg32Bit, cfgRtc, pwmModeA, pwmModeB, edgeModeA, edgeModeB} <= 8'h00;
    {countA, countB, edgeStampA, edgeStampB, prescaleCountA, prescaleCountB} <= 80'h0;
    address <= 12'h000;
    writedata <= 32'h0;
    byteenable <= 4'hf;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`TMPS_OFS_A_LOAD, 32'h0000ffff);
    rd_chk(`TMPS_OFS_B_LOAD, 32'h0000ffff);
    rd_chk(`TMPS_OFS_A_MATCH, 32'h0000ffff);
    rd_chk(`TMPS_OFS_B_MATCH, 32'h0000ffff);
    rd_chk(`TMPS_OFS_A_PRESCALE, 32'h0);
    rd_chk(`TMPS_OFS_B_PRESCALE, 32'h0);
    rd_chk(`TMPS_OFS_A_PRE_MATCH, 32'h0);
    rd_chk(`TMPS_OFS_B_PRE_MATCH, 32'h0);
    wr_chk(`TMPS_OFS_B_LOAD, 32'hffff1234, 32'h00001234);
    wr_chk(`TMPS_OFS_B_MATCH, 32'habcd5678, 32'h00005678);
    wr_chk(`TMPS_OFS_A_MATCH, 32'h9999aaaa, 32'h0000aaaa);
    rd_chk(`TMPS_OFS_B_MATCH, 32'h00005678);
    byteenable <= 4'h1;
    wr_chk(`TMPS_OFS_B_MATCH, 32'h00000011, 32'h00005611);
    byteenable <= 4'hf;
    wr_chk(`TMPS_OFS_A_LOAD, 32'h5555beef, 32'h0000beef);
    rd_chk(`TMPS_OFS_B_LOAD, 32'h00001234);
    wr_chk(`TMPS_OFS_A_PRESCALE, 32'h123456a5, 32'h000000a5);
    wr_chk(`TMPS_OFS_B_PRESCALE, 32'hffffff5a, 32'h0000005a);
    wr_chk(`TMPS_OFS_A_PRE_MATCH, 32'h8888883c, 32'h0000003c);
    wr_chk(`TMPS_OFS_B_PRE_MATCH, 32'h777777c3, 32'h000000c3);
    wr_chk(12'h050, 32'h12345678, 32'h0);
    `CHK("prescaleA", 8'ha5, prescaleA)
    `CHK("prescaleB", 8'h5a, prescaleB)
    `CHK("loadA", 16'hbeef, loadA)
    cfg32Bit <= 1'b1;
    wr_chk(`TMPS_OFS_B_LOAD, 32'h00000777, 32'h00001234);
    wr_chk(`TMPS_OFS_A_LOAD, 32'h4321beef, 32'h4321beef);
    rd_chk(`TMPS_OFS_B_LOAD, 32'h00004321);
    wr_chk(`TMPS_OFS_A_MATCH, 32'h22223333, 32'h22223333);
    rd_chk(`TMPS_OFS_B_MATCH, 32'h00002222);
    cfgRtc <= 1'b1;
    countA <= 16'h3333;
    countB <= 16'h2222;
    tick;
    `CHK("rtcMatch", 1'b1, rtcMatch)
    @(posedge clk);
    countA <= 16'h3334;
    tick;
    `CHK("rtcMatch", 1'b0, rtcMatch)
    @(posedge clk);
    countA <= 16'h3333;
    cfgRtc <= 1'b0;
    tick;
    `CHK("rtcMatch", 1'b0, rtcMatch)
    rd_chk(`TMPS_OFS_A_VALUE, 32'h22223333);
    edgeModeA <= 1'b1;
    edgeStampA <= 16'h0abc;
    rd_chk(`TMPS_OFS_A_VALUE, 32'h22220abc);
    cfg32Bit <= 1'b0;
    edgeModeB <= 1'b1;
    edgeStampB <= 16'h0bcd;
    rd_chk(`TMPS_OFS_A_VALUE, 32'h00000abc);
    rd_chk(`TMPS_OFS_B_VALUE, 32'h00000bcd);
    tick;
    `CHK("edgeTotalA", 16'hbeef - 16'h3333, edgeTotalA)
    `CHK("edgeTotalB", 16'h4321 - 16'h2222, edgeTotalB)
    @(posedge clk);
    edgeModeA <= 1'b0;
    pwmModeA <= 1'b1;
    countA <= 16'h4000;
    tick;
    `CHK("pwmOutA", 1'b1, pwmOutA)
    @(posedge clk);
    countA <= 16'h3333;
    tick;
    `CHK("pwmOutA", 1'b0, pwmOutA)
    @(posedge clk);
    prescaleCountA <= 8'h3c;
    tick;
    `CHK("matchEventA", 1'b1, matchEventA)
    @(posedge clk);
    prescaleCountA <= 8'h3d;
    tick;
    `CHK("matchEventA", 1'b0, matchEventA)
    bus_acc(1'b1, `TMPS_OFS_B_PRESCALE, 32'h0);
    tick;
    `CHK("matchEventB", 1'b1, matchEventB)
    @(posedge clk);
    pwmModeB <= 1'b1;
    countB <= 16'h2223;
    tick;
    `CHK("pwmOutB", 1'b1, pwmOutB)
    @(posedge clk);
    countB <= 16'h2222;
    cfg32Bit <= 1'b1;
    tick;
    `CHK("matchEventB", 1'b0, matchEventB)
    `CHK("pwmOutB", 1'b0, pwmOutB)
    @(posedge clk);
    reset_n <= 1'b0;
    tick;
    `CHK("loadB", 16'hffff, loadB)
    `CHK("prescaleA", 8'h00, prescaleA)
    @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`TMPS_OFS_A_MATCH, 32'hffffffff);
    rd_chk(`TMPS_OFS_A_LOAD, 32'hffffffff);
    print_verdict;
  end
endmodule // tmps_timer_regs_test
